// File: core/acfgp_port.sv
// Serial configuration port and register bank of an octal ADC
// Operation
// R01: Shift data on rising clock while selected
// R02: Commit word on every 24th rising edge
// R03: Several words per select are separate writes
// R04: Surplus bits resolved as further words
// R05: First eight bits address, sixteen data
// R06: Host keeps serial clock at most 20 MHz
// R07: Host resets then power-cycles at start-up
// R08: Short low reset pin pulse resets device
// R09: Soft reset bit restores defaults, self-clears
// R10: Host avoids reset pin when using soft reset
// R11: Short high power pin pulse power-cycles
// R12: Host may power-cycle by register writes
// R13: Power register: channels, sleep, off, pin mode
// R14: Three LVDS drive fields, default 3.5 mA
// R15: Termination fields apply only when enabled
// R16: Per-channel analog input polarity swap
// R17: One-hot ramp, dual, single pattern select
// R18: Single constant code, dual alternates codes
// R19: First custom code in D15:D2
// R20: Second custom code in D15:D2
// R21: Partial word at select rise is dropped
`timescale 1ns/100ps
`include "acfgp_cfg.svh"

module acfgp_port (
    input  wire logic               clock,
    input  wire logic               rstn,
    input  wire logic               chip_select_low,
    input  wire logic               serial_clock,
    input  wire logic               serial_data_in,
    input  wire logic               hard_reset_low_pin,
    input  wire logic               power_down_pin,
    input  wire logic               sample_tick,
    output acfgp_pkg::acfgp_regs_t    config_regs,
    output acfgp_pkg::acfgp_power_t   power_state,
    output acfgp_pkg::acfgp_lvds_t    lvds_state,
    output acfgp_pkg::acfgp_pattern_t pattern_out,
    output logic                    soft_reset_pulse
);
    import acfgp_pkg::*;

    acfgp_state_all_t st;
    acfgp_state_all_t next_st;
    logic             sclk_s;
    logic             csn_s;
    logic             serial_data_in_s;
    logic             hard_reset_evt;
    logic             power_pin_evt;
    logic             sclk_rise;
    logic [23:0]      word;
    logic [7:0]       addr;
    logic [15:0]      data;

    // Serial pins cross into the clock domain through two flops each
    acfgp_sync #(.CATCH(1'b0), .ACTIVE(1'b1)) u_sync_sclk (
        .clock (clock),
        .rstn  (rstn),
        .pin   (serial_clock),
        .level (sclk_s)
    );

    acfgp_sync #(.CATCH(1'b0), .ACTIVE(1'b1)) u_sync_csn (
        .clock (clock),
        .rstn  (rstn),
        .pin   (chip_select_low),
        .level (csn_s)
    );

    acfgp_sync #(.CATCH(1'b0), .ACTIVE(1'b1)) u_sync_serial_data_in (
        .clock (clock),
        .rstn  (rstn),
        .pin   (serial_data_in),
        .level (serial_data_in_s)
    );

    // Reset pin pulses may be far shorter than a clock period, so they are caught
    acfgp_sync #(.CATCH(1'b1), .ACTIVE(1'b0)) u_sync_reset (
        .clock (clock),
        .rstn  (rstn),
        .pin   (hard_reset_low_pin),
        .level (hard_reset_evt)
    ); // R08

    // Power-down pin: level while held, stretched by the catcher after release
    acfgp_sync #(.CATCH(1'b1), .ACTIVE(1'b1)) u_sync_power (
        .clock (clock),
        .rstn  (rstn),
        .pin   (power_down_pin),
        .level (power_pin_evt)
    ); // R11

    // Register bank reset values
    function automatic acfgp_regs_t acfgp_defaults();
        acfgp_regs_t r;
        r                           = '0;
        r.channel_power_off_bits    = `ACFGP_BYTE_DEFAULT;
        r.power_pin_function_select = `ACFGP_PIN_CFG_PD;
        r.drive_bit_clock           = `ACFGP_DRIVE_DEFAULT;
        r.drive_frame_clock         = `ACFGP_DRIVE_DEFAULT;
        r.drive_data                = `ACFGP_DRIVE_DEFAULT;
        r.term_bit_clock            = `ACFGP_TERM_DEFAULT;
        r.term_frame_clock          = `ACFGP_TERM_DEFAULT;
        r.term_data                 = `ACFGP_TERM_DEFAULT;
        r.input_swap_bits           = `ACFGP_BYTE_DEFAULT;
        r.first_pattern_code        = `ACFGP_CODE_DEFAULT;
        r.second_pattern_code       = `ACFGP_CODE_DEFAULT;
        return r;
    endfunction

    // Outputs are fields of the registered state
    assign config_regs      = st.regs;
    assign power_state      = st.power;
    assign lvds_state       = st.lvds;
    assign pattern_out      = st.pattern;
    assign soft_reset_pulse = st.soft_reset_pulse;

    // Rising edge of the sampled serial clock; data sampled with equal delay
    assign sclk_rise = sclk_s & ~st.sclk_prev; // R01
    assign word      = {st.shift[`ACFGP_WORD_BITS-2:0], serial_data_in_s}; // R05
    assign addr      = word[`ACFGP_ADDR_MSB:`ACFGP_ADDR_LSB]; // R05
    assign data      = word[`ACFGP_DATA_MSB:`ACFGP_DATA_LSB]; // R05

    // Next-state logic: serial shifter, register writes, pattern and power
    always_comb begin
        next_st                  = st;
        next_st.sclk_prev        = sclk_s;
        next_st.soft_reset_pulse = 1'b0;

        // Serial shifter; select high abandons any partial word
        case (st.state)
            ACFGP_IDLE: begin
                next_st.bit_count = `ACFGP_CNT_ZERO;
                if (!csn_s) begin
                    next_st.state = ACFGP_SHIFT;
                end
            end
            ACFGP_SHIFT: begin
                if (csn_s) begin
                    next_st.state     = ACFGP_IDLE; // R21
                    next_st.bit_count = `ACFGP_CNT_ZERO; // R21
                end else if (sclk_rise) begin
                    next_st.shift = word; // R01
                    if (st.bit_count == `ACFGP_CNT_LAST) begin
                        // Counter wraps so further words in this select are kept
                        next_st.bit_count = `ACFGP_CNT_ZERO; // R03 R04
                        case (addr) // R02
                            `ACFGP_ADDR_SOFT_RESET: begin
                                if (data[`ACFGP_SOFT_RESET_BIT]) begin
                                    // Bit is never stored, so it reads back as cleared
                                    next_st.regs             = acfgp_defaults(); // R09
                                    next_st.soft_reset_pulse = 1'b1; // R09
                                end
                            end
                            `ACFGP_ADDR_POWER: begin
                                next_st.regs.channel_power_off_bits =
                                    data[`ACFGP_CHAN_OFF_MSB:`ACFGP_CHAN_OFF_LSB]; // R13
                                next_st.regs.sleep = data[`ACFGP_SLEEP_BIT]; // R13
                                next_st.regs.full_power_off_bit =
                                    data[`ACFGP_FULL_OFF_BIT]; // R13
                                next_st.regs.power_pin_function_select =
                                    data[`ACFGP_PIN_CFG_MSB:`ACFGP_PIN_CFG_LSB]; // R13
                            end
                            `ACFGP_ADDR_DRIVE: begin
                                next_st.regs.drive_bit_clock =
                                    data[`ACFGP_BCLK_MSB:`ACFGP_BCLK_LSB]; // R14
                                next_st.regs.drive_frame_clock =
                                    data[`ACFGP_FCLK_MSB:`ACFGP_FCLK_LSB]; // R14
                                next_st.regs.drive_data =
                                    data[`ACFGP_DOUT_MSB:`ACFGP_DOUT_LSB]; // R14
                            end
                            `ACFGP_ADDR_TERM: begin
                                next_st.regs.term_enable = data[`ACFGP_TERM_EN_BIT]; // R15
                                next_st.regs.term_bit_clock =
                                    data[`ACFGP_BCLK_MSB:`ACFGP_BCLK_LSB]; // R15
                                next_st.regs.term_frame_clock =
                                    data[`ACFGP_FCLK_MSB:`ACFGP_FCLK_LSB]; // R15
                                next_st.regs.term_data =
                                    data[`ACFGP_DOUT_MSB:`ACFGP_DOUT_LSB]; // R15
                            end
                            `ACFGP_ADDR_SWAP: begin
                                next_st.regs.input_swap_bits =
                                    data[`ACFGP_SWAP_MSB:`ACFGP_SWAP_LSB]; // R16
                            end
                            `ACFGP_ADDR_PATTERN: begin
                                next_st.regs.pattern_ramp   = data[`ACFGP_RAMP_BIT]; // R17
                                next_st.regs.pattern_dual   = data[`ACFGP_DUAL_BIT]; // R17
                                next_st.regs.pattern_single = data[`ACFGP_SINGLE_BIT]; // R17
                            end
                            `ACFGP_ADDR_CODE1: begin
                                next_st.regs.first_pattern_code =
                                    data[`ACFGP_CODE_MSB:`ACFGP_CODE_LSB]; // R19
                            end
                            `ACFGP_ADDR_CODE2: begin
                                next_st.regs.second_pattern_code =
                                    data[`ACFGP_CODE_MSB:`ACFGP_CODE_LSB]; // R20
                            end
                            default: begin
                                // Unmapped addresses are ignored
                                next_st.regs = st.regs;
                            end
                        endcase
                    end else begin
                        next_st.bit_count = st.bit_count + `ACFGP_CNT_ONE; // R02
                    end
                end
            end
            default: begin
                next_st.state     = ACFGP_IDLE;
                next_st.bit_count = `ACFGP_CNT_ZERO;
            end
        endcase

        // Reset pin wins over any write landing in the same cycle
        if (hard_reset_evt) begin
            next_st.regs          = acfgp_defaults(); // R08
            next_st.pattern_phase = 1'b0;
        end

        // Test pattern: ramp over dual over single if several bits are set
        if (sample_tick) begin
            next_st.pattern.valid = next_st.regs.pattern_ramp | next_st.regs.pattern_dual |
                                    next_st.regs.pattern_single; // R17
            if (next_st.regs.pattern_ramp) begin
                next_st.pattern.code = st.pattern.code + `ACFGP_RAMP_STEP; // R17
            end else if (next_st.regs.pattern_dual) begin
                // Phase toggles per sample: first code, then second, then first
                next_st.pattern_phase = ~st.pattern_phase; // R18
                next_st.pattern.code  = st.pattern_phase ? next_st.regs.second_pattern_code
                                                         : next_st.regs.first_pattern_code; // R18
            end else if (next_st.regs.pattern_single) begin
                next_st.pattern.code  = next_st.regs.first_pattern_code; // R18
                next_st.pattern_phase = 1'b0;
            end else begin
                next_st.pattern.code  = `ACFGP_CODE_DEFAULT;
                next_st.pattern_phase = 1'b0;
            end
        end

        // Power pin meaning depends on its configured function
        next_st.power.channel_off = next_st.regs.channel_power_off_bits; // R13
        next_st.power.power_off   = next_st.regs.full_power_off_bit |
            (power_pin_evt &
             (next_st.regs.power_pin_function_select == `ACFGP_PIN_CFG_PD)); // R11 R13
        next_st.power.sleep       = next_st.regs.sleep |
            (power_pin_evt &
             (next_st.regs.power_pin_function_select != `ACFGP_PIN_CFG_PD)); // R13

        // Termination values only reach the buffers when enabled
        next_st.lvds.drive_bit_clock   = next_st.regs.drive_bit_clock; // R14
        next_st.lvds.drive_frame_clock = next_st.regs.drive_frame_clock; // R14
        next_st.lvds.drive_data        = next_st.regs.drive_data; // R14
        next_st.lvds.term_bit_clock    = next_st.regs.term_enable ?
            next_st.regs.term_bit_clock : `ACFGP_TERM_DEFAULT; // R15
        next_st.lvds.term_frame_clock  = next_st.regs.term_enable ?
            next_st.regs.term_frame_clock : `ACFGP_TERM_DEFAULT; // R15
        next_st.lvds.term_data         = next_st.regs.term_enable ?
            next_st.regs.term_data : `ACFGP_TERM_DEFAULT; // R15
    end

    // Whole state in one register; reset gives the documented defaults
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule // acfgp_port

// File: core/acfgp_cfg.svh
// Constants of the ADC serial configuration port: addresses, fields, defaults
`ifndef ACFGP_CFG_SVH
`define ACFGP_CFG_SVH

// Serial word framing: address first, then data, MSB first
`define ACFGP_WORD_BITS       24
`define ACFGP_CNT_LAST        5'h17
`define ACFGP_CNT_ZERO        5'h00
`define ACFGP_CNT_ONE         5'h01
`define ACFGP_ADDR_MSB        23
`define ACFGP_ADDR_LSB        16
`define ACFGP_DATA_MSB        15
`define ACFGP_DATA_LSB        0

// Register addresses
`define ACFGP_ADDR_SOFT_RESET 8'h00
`define ACFGP_ADDR_POWER      8'h0F
`define ACFGP_ADDR_DRIVE      8'h11
`define ACFGP_ADDR_TERM       8'h12
`define ACFGP_ADDR_SWAP       8'h24
`define ACFGP_ADDR_PATTERN    8'h25
`define ACFGP_ADDR_CODE1      8'h26
`define ACFGP_ADDR_CODE2      8'h27

// Field positions
`define ACFGP_SOFT_RESET_BIT  0
`define ACFGP_CHAN_OFF_MSB    7
`define ACFGP_CHAN_OFF_LSB    0
`define ACFGP_SLEEP_BIT       8
`define ACFGP_FULL_OFF_BIT    9
`define ACFGP_PIN_CFG_MSB     11
`define ACFGP_PIN_CFG_LSB     10
`define ACFGP_BCLK_MSB        2
`define ACFGP_BCLK_LSB        0
`define ACFGP_FCLK_MSB        5
`define ACFGP_FCLK_LSB        3
`define ACFGP_DOUT_MSB        10
`define ACFGP_DOUT_LSB        8
`define ACFGP_TERM_EN_BIT     14
`define ACFGP_SWAP_MSB        7
`define ACFGP_SWAP_LSB        0
`define ACFGP_RAMP_BIT        6
`define ACFGP_DUAL_BIT        5
`define ACFGP_SINGLE_BIT      4
`define ACFGP_CODE_MSB        15
`define ACFGP_CODE_LSB        2

// Reset values and ramp step
`define ACFGP_DRIVE_DEFAULT   3'h0
`define ACFGP_TERM_DEFAULT    3'h0
`define ACFGP_PIN_CFG_PD      2'h0
`define ACFGP_CODE_DEFAULT    14'h0000
`define ACFGP_BYTE_DEFAULT    8'h00
`define ACFGP_RAMP_STEP       14'h0001

`endif

// File: core/acfgp_pkg.sv
// Types shared by the ADC serial configuration port
package acfgp_pkg;

    // Serial port state, Gray coded
    typedef enum logic [1:0] {
        ACFGP_IDLE  = 2'b00,
        ACFGP_SHIFT = 2'b01
    } acfgp_state_t;

    // Configuration register bank contents
    typedef struct packed {
        logic [7:0]  channel_power_off_bits;
        logic        sleep;
        logic        full_power_off_bit;
        logic [1:0]  power_pin_function_select;
        logic [2:0]  drive_bit_clock;
        logic [2:0]  drive_frame_clock;
        logic [2:0]  drive_data;
        logic        term_enable;
        logic [2:0]  term_bit_clock;
        logic [2:0]  term_frame_clock;
        logic [2:0]  term_data;
        logic [7:0]  input_swap_bits;
        logic        pattern_ramp;
        logic        pattern_dual;
        logic        pattern_single;
        logic [13:0] first_pattern_code;
        logic [13:0] second_pattern_code;
    } acfgp_regs_t;

    // Power state seen by the analog core
    typedef struct packed {
        logic       power_off;
        logic       sleep;
        logic [7:0] channel_off;
    } acfgp_power_t;

    // LVDS settings in effect
    typedef struct packed {
        logic [2:0] drive_bit_clock;
        logic [2:0] drive_frame_clock;
        logic [2:0] drive_data;
        logic [2:0] term_bit_clock;
        logic [2:0] term_frame_clock;
        logic [2:0] term_data;
    } acfgp_lvds_t;

    // Test pattern sample stream
    typedef struct packed {
        logic        valid;
        logic [13:0] code;
    } acfgp_pattern_t;

    // Input synchroniser / pulse catcher state
    typedef struct packed {
        logic caught;
        logic s1;
        logic s2;
    } acfgp_sync_state_t;

    // Whole state of the port
    typedef struct packed {
        acfgp_state_t   state;
        logic           sclk_prev;
        logic [4:0]     bit_count;
        logic [23:0]    shift;
        acfgp_regs_t    regs;
        logic           soft_reset_pulse;
        logic           pattern_phase;
        acfgp_pattern_t pattern;
        acfgp_power_t   power;
        acfgp_lvds_t    lvds;
    } acfgp_state_all_t;

endpackage

// File: core/acfgp_sync.sv
// Two-stage input synchroniser with optional catcher for short pulses
`timescale 1ns/100ps

module acfgp_sync #(
    parameter bit CATCH  = 1'b0,
    parameter bit ACTIVE = 1'b1
) (
    input  wire logic clock,
    input  wire logic rstn,
    input  wire logic pin,
    output logic      level
);
    import acfgp_pkg::*;

    acfgp_sync_state_t st;
    acfgp_sync_state_t next_st;
    logic              set_async;

    // A pulse shorter than a clock period must still register, so it sets the catcher directly
    assign set_async = CATCH & (pin == ACTIVE);
    assign level     = st.s2;

    // Plain mode copies the pin; catch mode holds the event until seen downstream
    always_comb begin
        next_st = st;
        if (CATCH) begin
            next_st.s1 = st.caught;
            if (st.s2) begin
                next_st.caught = 1'b0;
            end
        end else begin
            next_st.caught = 1'b0;
            next_st.s1     = pin;
        end
        next_st.s2 = st.s1;
    end

    // First stage is read only by the second
    always_ff @(posedge clock or negedge rstn or posedge set_async) begin
        if (!rstn) begin
            st <= '0;
        end else if (set_async) begin
            st <= '1;
        end else begin
            st <= next_st;
        end
    end
endmodule // acfgp_sync

// File: tb/acfgp_host.sv
// Host model driving the three-wire configuration link
`timescale 1ns/100ps

module acfgp_host (
    input  wire logic clock,
    output logic      chip_select_low,
    output logic      serial_clock,
    output logic      serial_data_in
);
    // Idle link: deselected, clock parked low
    initial begin
        chip_select_low = 1'b1;
        serial_clock    = 1'b0;
        serial_data_in  = 1'b0;
    end

    // Half a link period, four system clocks: 400 ns per bit
    task automatic half();
        repeat (4) @(posedge clock);
        #1;
    endtask

    // Select setup kept well beyond two clocks
    task automatic sel_on();
        chip_select_low = 1'b0;
        half();
    endtask

    // Released data shows the inverse so a stale bit never passes
    task automatic sel_off();
        half();
        chip_select_low = 1'b1;
        serial_data_in  = ~serial_data_in;
        half();
    endtask

    // Data set while clock low, taken at the rise
    task automatic put_bit(input logic b);
        serial_data_in = b;
        half();
        serial_clock = 1'b1;
        half();
        serial_clock = 1'b0;
    endtask

    // Address byte first, then data, most significant bit first
    task automatic put_word(input logic [7:0] addr, input logic [15:0] data);
        logic [23:0] w;
        w = {addr, data};
        for (int i = 23; i >= 0; i--) begin
            put_bit(w[i]);
        end
    endtask
endmodule // acfgp_host

// File: tb/acfgp_port_monitor.sv
// Checker of the configuration port outputs
`timescale 1ns/100ps

module acfgp_port_monitor (
    input wire logic                      clock,
    input wire logic                      rstn,
    input wire logic                      chip_select_low,
    input wire logic                      hard_reset_low_pin,
    input wire logic                      power_down_pin,
    input wire logic                      sample_tick,
    input wire acfgp_pkg::acfgp_regs_t    config_regs,
    input wire acfgp_pkg::acfgp_power_t   power_state,
    input wire acfgp_pkg::acfgp_lvds_t    lvds_state,
    input wire acfgp_pkg::acfgp_pattern_t pattern_out,
    input wire logic                      soft_reset_pulse
);
    import acfgp_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);

    // Termination settings reach the buffers only when enabled
    wire logic [8:0] term_cfg = {config_regs.term_bit_clock, config_regs.term_frame_clock,
                                 config_regs.term_data};
    wire logic [8:0] term_out = {lvds_state.term_bit_clock, lvds_state.term_frame_clock,
                                 lvds_state.term_data};
    property p_term_gate;
        term_out == (config_regs.term_enable ? term_cfg : 9'h000);
    endproperty
    a_term_gate: assert property (p_term_gate) else $error("termination gating wrong");

    property p_drive;
        lvds_state[17:9] == {config_regs.drive_bit_clock, config_regs.drive_frame_clock,
                             config_regs.drive_data};
    endproperty
    a_drive: assert property (p_drive) else $error("drive fields differ");

    property p_chan;
        power_state.channel_off == config_regs.channel_power_off_bits;
    endproperty
    a_chan: assert property (p_chan) else $error("channel power bits differ");

    // Pattern priority: ramp over dual over single
    property p_single;
        sample_tick && config_regs.pattern_single && !config_regs.pattern_dual
            && !config_regs.pattern_ramp |=>
            pattern_out.code == $past(config_regs.first_pattern_code);
    endproperty
    a_single: assert property (p_single) else $error("single pattern code wrong");

    property p_dual;
        sample_tick && config_regs.pattern_dual && !config_regs.pattern_ramp |=>
            pattern_out.code == $past(config_regs.first_pattern_code)
            || pattern_out.code == $past(config_regs.second_pattern_code);
    endproperty
    a_dual: assert property (p_dual) else $error("dual pattern code wrong");

    property p_ramp;
        sample_tick && config_regs.pattern_ramp |=>
            pattern_out.code == 14'($past(pattern_out.code) + 14'h0001);
    endproperty
    a_ramp: assert property (p_ramp) else $error("ramp step wrong");

    property p_soft;
        soft_reset_pulse |=> !soft_reset_pulse && config_regs == '0;
    endproperty
    a_soft: assert property (p_soft) else $error("soft reset did not clear bank");

    // Without select or reset pin activity the bank must hold
    property p_quiet;
        (chip_select_low && hard_reset_low_pin) [*8] |=> $stable(config_regs);
    endproperty
    a_quiet: assert property (p_quiet) else $error("bank changed while idle");

    property p_pd_pin;
        power_down_pin [*5] ##0 (config_regs.power_pin_function_select == 2'h0) |->
            power_state.power_off;
    endproperty
    a_pd_pin: assert property (p_pd_pin) else $error("power pin ignored");

    property p_hard;
        $fell(hard_reset_low_pin) |-> ##[1:10] (config_regs == '0);
    endproperty
    a_hard: assert property (p_hard) else $error("reset pin did not clear bank");
endmodule // acfgp_port_monitor

bind acfgp_port acfgp_port_monitor u_acfgp_port_monitor (.clock, .rstn, .chip_select_low,
    .hard_reset_low_pin, .power_down_pin, .sample_tick, .config_regs, .power_state,
    .lvds_state, .pattern_out, .soft_reset_pulse);

// File: tb/tb_top.sv
// Testbench of the ADC configuration port
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
    $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end

module tb_top;
    import acfgp_pkg::*;
    logic             clock, rstn, hard_reset_low_pin, power_down_pin, sample_tick;
    logic             chip_select_low, serial_clock, serial_data_in, soft_reset_pulse;
    acfgp_regs_t      config_regs, e;
    acfgp_power_t     power_state;
    acfgp_lvds_t      lvds_state;
    acfgp_pattern_t   pattern_out;
    int               n_fail = 0, tests_run = 0, n_soft = 0;

    acfgp_host u_acfgp_host (.clock(clock), .chip_select_low(chip_select_low),
        .serial_clock(serial_clock), .serial_data_in(serial_data_in));
    acfgp_port u_acfgp_port (.clock(clock), .rstn(rstn), .chip_select_low(chip_select_low),
        .serial_clock(serial_clock), .serial_data_in(serial_data_in),
        .hard_reset_low_pin(hard_reset_low_pin), .power_down_pin(power_down_pin),
        .sample_tick(sample_tick), .config_regs(config_regs), .power_state(power_state),
        .lvds_state(lvds_state), .pattern_out(pattern_out),
        .soft_reset_pulse(soft_reset_pulse));

    // 20 MHz system clock
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // Pulses counted in the background, so commit timing cannot race the check
    always @(posedge clock) if (soft_reset_pulse === 1'b1) n_soft++;

    task automatic conclude();
        $display("Counts: %0d compares, %0d mismatches", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // One word in a frame of its own
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        u_acfgp_host.sel_on();
        u_acfgp_host.put_word(a, d);
        u_acfgp_host.sel_off();
    endtask

    // One sample tick, code checked on the following edge
    task automatic tick(input logic [13:0] exp);
        @(posedge clock);
        #1 sample_tick = 1'b1;
        @(posedge clock);
        #1 sample_tick = 0;
        `CHK(pattern_out, {1'b1, exp})
    endtask

    // Power pin held six clocks, state checked before release
    task automatic pin_pd(input logic [9:0] exp);
        power_down_pin = 1'b1;
        repeat (6) @(posedge clock);
        #1 `CHK(power_state, exp)
        power_down_pin = 1'b0;
        repeat (8) @(posedge clock);
        #1;
    endtask

    // Hang guard
    initial begin
        #2ms n_fail++;
        conclude();
    end

    initial begin
        rstn = 1'b0;
        hard_reset_low_pin = 1'b1;
        power_down_pin = 1'b0;
        sample_tick = 1'b0;
        e = '0;
        repeat (20) @(posedge clock);
        #1 rstn = 1'b1;
        repeat (3) @(posedge clock);
        #1 `CHK(config_regs, e)
        `CHK(lvds_state, 18'h00000)
        $display("test defaults done");
        // Start-up power cycle through the register
        wr(8'h0F, 16'h0200);
        `CHK(power_state, 10'h200)
        wr(8'h0F, 16'h0000);
        `CHK(power_state, 10'h000)
        pin_pd(10'h200);
        `CHK(power_state, 10'h000)
        $display("test power cycle done");
        // Several words and an unmapped one in one select
        u_acfgp_host.sel_on();
        u_acfgp_host.put_word(8'h0F, 16'h085A);
        u_acfgp_host.put_word(8'h11, 16'h061D);
        u_acfgp_host.put_word(8'h12, 16'h0711);
        u_acfgp_host.put_word(8'h24, 16'h00C3);
        u_acfgp_host.put_word(8'h25, 16'h0010);
        u_acfgp_host.put_word(8'h26, 16'hAAF0);
        u_acfgp_host.put_word(8'h27, 16'h48D0);
        u_acfgp_host.put_word(8'h30, 16'hFFFF);
        u_acfgp_host.sel_off();
        e.channel_power_off_bits = 8'h5A;
        e.power_pin_function_select = 2'h2;
        {e.drive_bit_clock, e.drive_frame_clock, e.drive_data} = {3'h5, 3'h3, 3'h6};
        {e.term_bit_clock, e.term_frame_clock, e.term_data} = {3'h1, 3'h2, 3'h7};
        e.input_swap_bits = 8'hC3;
        e.pattern_single = 1'b1;
        e.first_pattern_code = 14'h2ABC;
        e.second_pattern_code = 14'h1234;
        `CHK(config_regs, e)
        `CHK(lvds_state, {3'h5, 3'h3, 3'h6, 9'h000})
        pin_pd({1'b0, 1'b1, 8'h5A});
        wr(8'h12, 16'h4711);
        e.term_enable = 1'b1;
        `CHK(lvds_state, {3'h5, 3'h3, 3'h6, 3'h1, 3'h2, 3'h7})
        $display("test multiword done");
        // Partial word dropped, following word still aligned
        u_acfgp_host.sel_on();
        for (int i = 0; i < 10; i++) u_acfgp_host.put_bit(1'b1);
        u_acfgp_host.sel_off();
        `CHK(config_regs, e)
        tick(14'h2ABC);
        tick(14'h2ABC);
        wr(8'h25, 16'h0020);
        for (int k = 0; k < 4; k++) tick(k[0] ? 14'h1234 : 14'h2ABC);
        wr(8'h25, 16'h0040);
        tick(14'h1235);
        tick(14'h1236);
        $display("test patterns done");
        // Soft reset without any reset pin pulse
        wr(8'h00, 16'h0001);
        e = '0;
        `CHK(n_soft, 1)
        `CHK(config_regs, e)
        $display("test soft reset done");
        wr(8'h24, 16'h00FF);
        hard_reset_low_pin = 1'b0;
        @(posedge clock);
        #1 hard_reset_low_pin = 1'b1;
        repeat (8) @(posedge clock);
        #1 `CHK(config_regs, e)
        $display("test reset pin done");
        conclude();
    end
endmodule // tb_top
